/* core/rtp_pkg.sv */
package rtp_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int BYTE_W    = 8;
   localparam int PTR_W     = 6;
   localparam int MEM_DEPTH = 64;
   localparam int TIME_REGS = 7;
   localparam int CNT_W     = 4;
   localparam int SYNC_W    = 3;
   localparam int TIME_W    = TIME_REGS * BYTE_W;
   localparam int ADDR_W    = 7;

   localparam logic [ADDR_W-1:0] SLAVE_ADDR   = 7'h68;
   localparam logic [CNT_W-1:0]  CNT_ONE      = 4'h1;
   localparam logic [CNT_W-1:0]  CNT_TX_LAST  = 4'h7;
   localparam logic [CNT_W-1:0]  CNT_BYTE     = 4'h8;
   localparam logic [PTR_W-1:0]  PTR_ONE      = 6'h01;
   localparam logic [PTR_W-1:0]  PTR_TIME_END = 6'h07;
   localparam logic [BYTE_W-1:0] LEN_ZERO     = 8'h00;
   localparam logic [BYTE_W-1:0] LEN_ONE      = 8'h01;
   localparam logic [1:0]        PH_SET       = 2'h0;
   localparam logic [1:0]        PH_RISE      = 2'h1;
   localparam logic [1:0]        PH_MID       = 2'h2;
   localparam logic [1:0]        PH_FALL      = 2'h3;
   localparam logic [1:0]        PH_ONE       = 2'h1;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_KHZ     = 40000;
   localparam int SCL_KHZ     = 100;
   localparam int QTR_PER_BIT = 4;
   localparam int QTR_CYC     = (CLK_KHZ + QTR_PER_BIT * SCL_KHZ - 1) / (QTR_PER_BIT * SCL_KHZ);
   localparam int COND_QTRS   = 2;
   localparam int TCNT_W      = 9;

   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {D_IDLE, D_RECV, D_ACK, D_TX, D_RACK} rtp_dstate_t;
   typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} rtp_kind_t;
   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} rtp_hstate_t;
   typedef enum logic [2:0] {S_WADDR, S_PTR, S_WDATA, S_RADDR, S_RDATA} rtp_step_t;

endpackage

/* core/rtp_bus_if.sv */
`timescale 1ns/10ps
interface rtp_bus_if;
   logic scl;
   logic sda;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;

   // open drain wires with pull-up
   assign scl = !(host_scl_oe && !host_scl_o);
   assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

   modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
                 output host_sda_oe, input scl, input sda);
   modport dev  (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface

/* core/rtp_dev_end.sv */
`timescale 1ns/10ps
// How it works
// - every received byte except a non-matching address gets an acknowledge
// - bytes shift most significant bit first
// - master acks reads except final byte
// - master makes clock, start and stop
// - stop or repeated start ends transfer
// - start begins transfer, stop ends it
// - address 1101000, direction 0 writes
// - direction 1 reads, device transmits
// - matching address byte is acknowledged
// - first written byte loads register pointer
// - later written bytes stored and acknowledged
// - master ends writes with stop
// - reads start at register pointer
// - pointer kept between accesses
// - read ends on master not-acknowledge
// - device drives data timed by serial clock
// - pointer wraps from last RAM to zero
// - start snapshots time into shadow registers
// - release data line after final nack
// - standard-mode clock rate only
module rtp_dev_end
   import rtp_pkg::*;
#(
   parameter logic [ADDR_W-1:0] ADDR = SLAVE_ADDR
) (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              link_clk_i,
   input  wire logic [TIME_W-1:0] time_i,
   output logic                   wr_valid_o,
   output logic [PTR_W-1:0]       wr_addr_o,
   output logic [BYTE_W-1:0]      wr_data_o,
   rtp_bus_if.dev                 bus
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [SYNC_W-1:0]                   rst_s;
      logic [SYNC_W-1:0]                   scl_s;
      logic [SYNC_W-1:0]                   sda_s;
      logic [SYNC_W-1:0]                   ack_s;
      logic                                scl_l;
      logic                                sda_l;
      logic                                ack_l;
      rtp_dstate_t                         st;
      rtp_kind_t                           kind;
      logic                                rw;
      logic                                nack;
      logic [CNT_W-1:0]                    cnt;
      logic [BYTE_W-1:0]                   sh;
      logic [PTR_W-1:0]                    ptr;
      logic                                sda_oe;
      logic                                snap_req;
      logic [TIME_REGS-1:0][BYTE_W-1:0]    shadow;
      logic                                wr_tgl;
      logic [PTR_W-1:0]                    wr_addr;
      logic [BYTE_W-1:0]                   wr_data;
      logic [MEM_DEPTH-1:0][BYTE_W-1:0]    mem;
   } rtp_link_t;

   typedef struct packed {
      logic [SYNC_W-1:0] req_s;
      logic              req_l;
      logic [TIME_W-1:0] hold;
      logic              ack_tgl;
      logic [SYNC_W-1:0] wr_s;
      logic              wr_l;
      logic              wr_valid;
      logic [PTR_W-1:0]  wr_addr;
      logic [BYTE_W-1:0] wr_data;
   } rtp_core_t;

   rtp_link_t lq;
   rtp_link_t ld;
   rtp_core_t cq;
   rtp_core_t cd;

   logic              link_rst;
   logic              scl_new;
   logic              sda_new;
   logic              scl_rise;
   logic              scl_fall;
   logic              bus_start;
   logic              bus_stop;
   logic              snap_evt;
   logic [BYTE_W-1:0] rd_now;

   // ------------------------------------------------------------
   // link side: sampled pins and bus conditions
   // ------------------------------------------------------------
   // a level change counts only once the last two stages agree
   assign link_rst  = !(lq.rst_s[SYNC_W-1] && lq.rst_s[SYNC_W-2]);
   assign scl_new   = (lq.scl_s[SYNC_W-1] == lq.scl_s[SYNC_W-2]) ? lq.scl_s[SYNC_W-1] : lq.scl_l;
   assign sda_new   = (lq.sda_s[SYNC_W-1] == lq.sda_s[SYNC_W-2]) ? lq.sda_s[SYNC_W-1] : lq.sda_l;
   assign scl_rise  = scl_new && !lq.scl_l;
   assign scl_fall  = !scl_new && lq.scl_l;
   assign bus_start = lq.scl_l && scl_new && lq.sda_l && !sda_new;
   assign bus_stop  = lq.scl_l && scl_new && !lq.sda_l && sda_new;
   assign snap_evt  = (lq.ack_s[SYNC_W-1] == lq.ack_s[SYNC_W-2])
                      && (lq.ack_s[SYNC_W-1] != lq.ack_l);

   // time registers come from the shadow copy, the rest from memory
   assign rd_now = (lq.ptr < PTR_TIME_END) ? lq.shadow[lq.ptr[2:0]] : lq.mem[lq.ptr];

   function automatic rtp_link_t tx_load(input rtp_link_t s, input logic [BYTE_W-1:0] b);
      rtp_link_t r;
      r        = s;
      r.sh     = b;
      r.sda_oe = !b[BYTE_W-1];
      r.cnt    = '0;
      r.ptr    = s.ptr + PTR_ONE;
      r.st     = D_TX;
      return r;
   endfunction

   always_comb begin
      ld       = lq;
      ld.rst_s = {lq.rst_s[SYNC_W-2:0], rst_n_i};
      ld.scl_s = {lq.scl_s[SYNC_W-2:0], bus.scl};
      ld.sda_s = {lq.sda_s[SYNC_W-2:0], bus.sda};
      ld.ack_s = {lq.ack_s[SYNC_W-2:0], cq.ack_tgl};
      ld.scl_l = scl_new;
      ld.sda_l = sda_new;
      if (snap_evt) begin
         ld.ack_l  = lq.ack_s[SYNC_W-1];
         ld.shadow = cq.hold;
      end
      if (bus_stop) begin
         ld.st     = D_IDLE;
         ld.sda_oe = 1'b0;
      end else if (bus_start) begin
         // a repeated start lands here too and restarts address matching
         ld.st       = D_RECV;
         ld.kind     = K_ADDR;
         ld.cnt      = '0;
         ld.sda_oe   = 1'b0;
         ld.snap_req = !lq.snap_req;
      end else begin
         unique case (lq.st)
            D_IDLE: begin
            end
            D_RECV: begin
               if (scl_rise) begin
                  ld.sh  = {lq.sh[BYTE_W-2:0], sda_new};
                  ld.cnt = lq.cnt + CNT_ONE;
               end else if (scl_fall && lq.cnt == CNT_BYTE) begin
                  ld.st     = D_ACK;
                  ld.sda_oe = 1'b1;
                  unique case (lq.kind)
                     K_ADDR: begin
                        if (lq.sh[BYTE_W-1:1] == ADDR) begin
                           ld.rw = lq.sh[0];
                        end else begin
                           ld.st     = D_IDLE;
                           ld.sda_oe = 1'b0;
                        end
                     end
                     K_PTR: begin
                        ld.ptr = lq.sh[PTR_W-1:0];
                     end
                     K_DATA: begin
                        ld.mem[lq.ptr] = lq.sh;
                        ld.wr_tgl      = !lq.wr_tgl;
                        ld.wr_addr     = lq.ptr;
                        ld.wr_data     = lq.sh;
                        ld.ptr         = lq.ptr + PTR_ONE;
                     end
                     default: begin
                        ld.st     = D_IDLE;
                        ld.sda_oe = 1'b0;
                     end
                  endcase
               end
            end
            D_ACK: begin
               if (scl_fall) begin
                  ld.sda_oe = 1'b0;
                  if (lq.rw) begin
                     ld = tx_load(ld, rd_now);
                  end else begin
                     ld.st   = D_RECV;
                     ld.cnt  = '0;
                     ld.kind = (lq.kind == K_ADDR) ? K_PTR : K_DATA;
                  end
               end
            end
            D_TX: begin
               // bits change only after the master pulls the clock low
               if (scl_fall) begin
                  if (lq.cnt == CNT_TX_LAST) begin
                     ld.sda_oe = 1'b0;
                     ld.st     = D_RACK;
                  end else begin
                     ld.sh     = {lq.sh[BYTE_W-2:0], 1'b0};
                     ld.sda_oe = !lq.sh[BYTE_W-2];
                     ld.cnt    = lq.cnt + CNT_ONE;
                  end
               end
            end
            D_RACK: begin
               if (scl_rise) begin
                  ld.nack = sda_new;
               end else if (scl_fall) begin
                  if (lq.nack) begin
                     ld.st     = D_IDLE;
                     ld.sda_oe = 1'b0;
                  end else begin
                     ld = tx_load(ld, rd_now);
                  end
               end
            end
            default: begin
               ld.st     = D_IDLE;
               ld.sda_oe = 1'b0;
            end
         endcase
      end
      if (link_rst) begin
         // pointer and memory content are cleared only by reset
         ld       = '0;
         ld.rst_s = {lq.rst_s[SYNC_W-2:0], rst_n_i};
         ld.scl_s = {lq.scl_s[SYNC_W-2:0], bus.scl};
         ld.sda_s = {lq.sda_s[SYNC_W-2:0], bus.sda};
         ld.ack_s = {lq.ack_s[SYNC_W-2:0], cq.ack_tgl};
         ld.scl_l = 1'b1;
         ld.sda_l = 1'b1;
      end
   end

   always_ff @(posedge link_clk_i) begin
      lq <= ld;
   end

   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_sda_oe = lq.sda_oe;

   // ------------------------------------------------------------
   // core side: time capture and write reports
   // ------------------------------------------------------------
   // hold word stays still until the next snapshot request; write words get no answer toggle
   always_comb begin
      cd          = cq;
      cd.req_s    = {cq.req_s[SYNC_W-2:0], lq.snap_req};
      cd.wr_s     = {cq.wr_s[SYNC_W-2:0], lq.wr_tgl};
      cd.wr_valid = 1'b0;
      if (cq.req_s[SYNC_W-1] == cq.req_s[SYNC_W-2] && cq.req_s[SYNC_W-1] != cq.req_l) begin
         cd.req_l   = cq.req_s[SYNC_W-1];
         cd.hold    = time_i;
         cd.ack_tgl = !cq.ack_tgl;
      end
      if (cq.wr_s[SYNC_W-1] == cq.wr_s[SYNC_W-2] && cq.wr_s[SYNC_W-1] != cq.wr_l) begin
         cd.wr_l     = cq.wr_s[SYNC_W-1];
         cd.wr_valid = 1'b1;
         cd.wr_addr  = lq.wr_addr;
         cd.wr_data  = lq.wr_data;
      end
      if (!rst_n_i) begin
         cd = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      cq <= cd;
   end

   assign wr_valid_o = cq.wr_valid;
   assign wr_addr_o  = cq.wr_addr;
   assign wr_data_o  = cq.wr_data;

endmodule

/* core/rtp_host_end.sv */
`timescale 1ns/10ps
module rtp_host_end
   import rtp_pkg::*;
#(
   parameter int QTR = QTR_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              cmd_valid_i,
   input  wire logic              cmd_rd_i,
   input  wire logic              cmd_use_ptr_i,
   input  wire logic [BYTE_W-1:0] cmd_ptr_i,
   input  wire logic [BYTE_W-1:0] cmd_len_i,
   input  wire logic [BYTE_W-1:0] wdata_i,
   output logic                   cmd_ready_o,
   output logic                   wtake_o,
   output logic                   rvalid_o,
   output logic [BYTE_W-1:0]      rdata_o,
   output logic                   done_o,
   output logic                   err_o,
   rtp_bus_if.host                bus
);

   localparam logic [TCNT_W-1:0] BIT_END  = TCNT_W'(QTR - 1);
   localparam logic [TCNT_W-1:0] COND_END = TCNT_W'(QTR * COND_QTRS - 1);
   localparam logic [TCNT_W-1:0] TCNT_ONE = 9'h001;

   typedef struct packed {
      rtp_hstate_t       st;
      rtp_step_t         step;
      logic [TCNT_W-1:0] tcnt;
      logic [1:0]        ph;
      logic [CNT_W-1:0]  bitn;
      logic [BYTE_W-1:0] sh;
      logic [SYNC_W-1:0] sda_s;
      logic              sda_l;
      logic              rd;
      logic              nack;
      logic [BYTE_W-1:0] ptr;
      logic [BYTE_W-1:0] len;
      logic              scl_oe;
      logic              sda_oe;
      logic              ready;
      logic              wtake;
      logic              rvalid;
      logic [BYTE_W-1:0] rdata;
      logic              done;
      logic              err;
   } rtp_host_t;

   rtp_host_t q;
   rtp_host_t d;
   logic      tick;
   logic      rx;

   // start and stop phases run two quarters for setup and hold margin
   assign tick = (q.tcnt == ((q.st == H_BIT) ? BIT_END : COND_END));
   assign rx   = (q.step == S_RDATA);

   function automatic rtp_host_t begin_byte(input rtp_host_t s, input logic [BYTE_W-1:0] b);
      rtp_host_t r;
      r        = s;
      r.st     = H_BIT;
      r.ph     = PH_SET;
      r.bitn   = '0;
      r.sh     = b;
      r.sda_oe = (r.step == S_RDATA) ? 1'b0 : !b[BYTE_W-1];
      return r;
   endfunction

   always_comb begin
      d        = q;
      d.sda_s  = {q.sda_s[SYNC_W-2:0], bus.sda};
      d.wtake  = 1'b0;
      d.rvalid = 1'b0;
      d.done   = 1'b0;
      if (q.sda_s[SYNC_W-1] == q.sda_s[SYNC_W-2]) begin
         d.sda_l = q.sda_s[SYNC_W-1];
      end
      d.tcnt = (tick || q.st == H_IDLE) ? '0 : q.tcnt + TCNT_ONE;
      unique case (q.st)
         H_IDLE: begin
            if (cmd_valid_i && q.ready) begin
               d.ready  = 1'b0;
               d.err    = 1'b0;
               d.rd     = cmd_rd_i;
               d.ptr    = cmd_ptr_i;
               d.len    = (cmd_rd_i && cmd_len_i == LEN_ZERO) ? LEN_ONE : cmd_len_i;
               d.step   = (cmd_rd_i && !cmd_use_ptr_i) ? S_RADDR : S_WADDR;
               d.st     = H_START;
               d.ph     = PH_SET;
               d.sda_oe = 1'b0;
            end
         end
         H_START: begin
            if (tick) begin
               d.ph = q.ph + PH_ONE;
               unique case (q.ph)
                  PH_SET:  d.scl_oe = 1'b0;
                  PH_RISE: d.sda_oe = 1'b1;
                  PH_MID:  d.scl_oe = 1'b1;
                  PH_FALL: d = begin_byte(d, {SLAVE_ADDR, q.step == S_RADDR});
               endcase
            end
         end
         H_BIT: begin
            if (tick) begin
               d.ph = q.ph + PH_ONE;
               unique case (q.ph)
                  PH_SET: d.scl_oe = 1'b0;
                  PH_RISE: begin
                     if (q.bitn != CNT_BYTE && rx) begin
                        d.sh = {q.sh[BYTE_W-2:0], q.sda_l};
                     end else if (q.bitn == CNT_BYTE && !rx) begin
                        d.nack = q.sda_l;
                     end
                  end
                  PH_MID: d.scl_oe = 1'b1;
                  PH_FALL: begin
                     if (q.bitn != CNT_BYTE) begin
                        d.bitn = q.bitn + CNT_ONE;
                        if (q.bitn == CNT_TX_LAST) begin
                           d.sda_oe = rx && (q.len != LEN_ONE);
                        end else if (!rx) begin
                           d.sh     = {q.sh[BYTE_W-2:0], 1'b0};
                           d.sda_oe = !q.sh[BYTE_W-2];
                        end
                     end else if (!rx && q.nack) begin
                        d.err    = 1'b1;
                        d.st     = H_STOP;
                        d.sda_oe = 1'b1;
                     end else begin
                        unique case (q.step)
                           S_WADDR: begin
                              d.step = S_PTR;
                              d = begin_byte(d, q.ptr);
                           end
                           S_PTR, S_WDATA: begin
                              if (q.rd) begin
                                 d.step   = S_RADDR;
                                 d.st     = H_START;
                                 d.sda_oe = 1'b0;
                              end else if (q.len == LEN_ZERO) begin
                                 d.st     = H_STOP;
                                 d.sda_oe = 1'b1;
                              end else begin
                                 d.step  = S_WDATA;
                                 d.wtake = 1'b1;
                                 d.len   = q.len - LEN_ONE;
                                 d = begin_byte(d, wdata_i);
                              end
                           end
                           S_RADDR: begin
                              d.step = S_RDATA;
                              d = begin_byte(d, q.sh);
                           end
                           S_RDATA: begin
                              d.rdata  = q.sh;
                              d.rvalid = 1'b1;
                              d.len    = q.len - LEN_ONE;
                              if (q.len == LEN_ONE) begin
                                 d.st     = H_STOP;
                                 d.sda_oe = 1'b1;
                              end else begin
                                 d = begin_byte(d, q.sh);
                              end
                           end
                           default: begin
                              d.st     = H_STOP;
                              d.sda_oe = 1'b1;
                           end
                        endcase
                     end
                  end
               endcase
            end
         end
         H_STOP: begin
            if (tick) begin
               d.ph = q.ph + PH_ONE;
               unique case (q.ph)
                  PH_SET:  d.scl_oe = 1'b0;
                  PH_RISE: d.sda_oe = 1'b0;
                  PH_MID: begin
                  end
                  PH_FALL: begin
                     d.st    = H_IDLE;
                     d.done  = 1'b1;
                     d.ready = 1'b1;
                  end
               endcase
            end
         end
      endcase
      if (!rst_n_i) begin
         d       = '0;
         d.sda_s = {q.sda_s[SYNC_W-2:0], bus.sda};
         d.sda_l = 1'b1;
         d.ready = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      q <= d;
   end

   assign bus.host_scl_o  = 1'b0;
   assign bus.host_sda_o  = 1'b0;
   assign bus.host_scl_oe = q.scl_oe;
   assign bus.host_sda_oe = q.sda_oe;
   assign cmd_ready_o     = q.ready;
   assign wtake_o         = q.wtake;
   assign rvalid_o        = q.rvalid;
   assign rdata_o         = q.rdata;
   assign done_o          = q.done;
   assign err_o           = q.err;

endmodule

/* test/rtp_bus_props.sv */
`timescale 1ns/10ps
module rtp_bus_props (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe
);
   // ------------------------------------------------------------
   // wire checks
   // ------------------------------------------------------------
   // link side leaves reset some link clocks after rst_n_i rises,
   // so the device pin is unknown for a short while
   logic [3:0] settle_q;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         settle_q <= 4'h0;
      end else if (settle_q != 4'hF) begin
         settle_q <= settle_q + 4'h1;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i || settle_q != 4'hF);
   sequence low_ph; !scl [*8]; endsequence
   sequence high_ph; scl [*8]; endsequence
   scl_low_min_a: assert property ($fell(scl) |-> low_ph)
      else $error("scl low phase too short");
   scl_high_min_a: assert property ($rose(scl) |-> high_ph)
      else $error("scl high phase too short");
   scl_period_a: assert property ($fell(scl) |-> ##[8:100] scl)
      else $error("scl low phase too long");
   dev_on_low_a: assert property ($rose(dev_sda_oe) |-> !scl)
      else $error("device took data line with scl high");
   dev_off_low_a: assert property ($fell(dev_sda_oe) |-> !scl)
      else $error("device released data line with scl high");
   dev_hold_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device data changed in scl high");
   dev_bounded_a: assert property ($rose(dev_sda_oe) |-> ##[1:700] !dev_sda_oe)
      else $error("device held data line too long");
   cond_idle_a: assert property (scl && $past(scl) && $changed(sda) |-> !dev_sda_oe)
      else $error("device drove during start or stop");
endmodule

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   import rtp_pkg::*;
   logic        clk_i, lk, rst_n_i, cv, crd, cup, wt, rv, dn, er, rdy, wv, wv2;
   logic [7:0]  cp, cl, wd, rd, wdat, wb[8], mem[64];
   logic [5:0]  wa;
   logic [55:0] tm;
   logic [15:0] wq[$], rq[$];
   logic [31:0] rs = 32'h0000DBCB;
   int          fails, comparisons, wi;
   rtp_bus_if b();
   rtp_bus_if b2();
   // second device with a near-miss address sees the same host
   assign b2.host_scl_o = b.host_scl_o;
   assign b2.host_scl_oe = b.host_scl_oe;
   assign b2.host_sda_o = b.host_sda_o;
   assign b2.host_sda_oe = b.host_sda_oe;
   assign wd = wb[wi];
   rtp_host_end #(.QTR(16)) rtp_host_end_inst (.clk_i, .rst_n_i, .cmd_valid_i(cv),
      .cmd_rd_i(crd), .cmd_use_ptr_i(cup), .cmd_ptr_i(cp), .cmd_len_i(cl), .wdata_i(wd),
      .cmd_ready_o(rdy), .wtake_o(wt), .rvalid_o(rv), .rdata_o(rd), .done_o(dn),
      .err_o(er), .bus(b.host));
   rtp_dev_end rtp_dev_end_inst (.clk_i, .rst_n_i, .link_clk_i(lk), .time_i(tm),
      .wr_valid_o(wv), .wr_addr_o(wa), .wr_data_o(wdat), .bus(b.dev));
   rtp_dev_end #(.ADDR(7'h69)) rtp_dev_end_inst_b (.clk_i, .rst_n_i, .link_clk_i(lk),
      .time_i(tm), .wr_valid_o(wv2), .wr_addr_o(), .wr_data_o(), .bus(b2.dev));
   rtp_bus_props rtp_bus_props_inst (.clk_i, .rst_n_i, .scl(b.scl), .sda(b.sda),
      .dev_sda_oe(b.dev_sda_oe));
   initial begin clk_i = 0; forever #12.5 clk_i = ~clk_i; end
   initial begin lk = 0; #7; forever #32 lk = ~lk; end
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function logic [31:0] xs();
      rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5;
      return rs;
   endfunction
   task chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task conclude;
      $display("counts: %0d compared, %0d wrong", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task xfer(input logic r, input logic u, input logic [7:0] p, input logic [7:0] l);
      logic [5:0] a;
      int n;
      for (int k = 0; k < l; k++) begin
         a = 6'(p + k);
         if (r) rq.push_back({8'h00, a < 7 ? tm[int'(a)*8+:8] : mem[a]});
         else begin
            wb[k] = 8'(xs()); mem[a] = wb[k]; wq.push_back({2'h0, a, wb[k]});
         end
      end
      n = 0; wi = 0;
      @(negedge clk_i); crd = r; cup = u; cp = p; cl = l; cv = 1;
      @(negedge clk_i); cv = 0;
      chk(16'(rdy), 16'h0000);
      while (!dn && n < 20000) begin @(negedge clk_i); n++; end
      chk(16'(n < 20000), 16'h0001);
      chk(16'(rdy), 16'h0001);
      chk(16'(wi), r ? 16'h0000 : 16'(l));
      chk(16'(er), 16'h0000);
      $display("test done: rd=%0d ptr=%h len=%0d", r, p, l);
   endtask
   always @(negedge clk_i) begin
      if (wt) wi++;
      if (rv) chk({8'h00, rd}, rq.pop_front());
      if (wv) chk({2'h0, wa, wdat}, wq.pop_front());
      if (wv2 || b2.dev_sda_oe) chk(16'h0001, 16'h0000);
   end
   initial begin #2ms; fails++; conclude; end
   initial begin
      logic [7:0] p;
      rst_n_i = 0; cv = 0; crd = 0; cup = 0; cp = 8'h00; cl = 8'h00; wi = 0;
      fails = 0; comparisons = 0; tm = 56'({xs(), xs()});
      foreach (wb[i]) wb[i] = 8'h00;
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (4) @(negedge clk_i);
      rst_n_i = 1;
      #1us;
      xfer(0, 1, 8'h3E, 8'h03);
      tm = 56'({xs(), xs()});
      xfer(1, 1, 8'h3D, 8'h04);
      tm = 56'({xs(), xs()});
      xfer(1, 0, 8'h01, 8'h02);
      xfer(0, 1, 8'h06, 8'h00);
      xfer(1, 0, 8'h06, 8'h02);
      p = 8'(xs());
      xfer(0, 1, p, 8'h05);
      xfer(1, 1, p, 8'h05);
      chk(16'(wq.size() + rq.size()), 16'h0000);
      conclude;
   end
endmodule
